// ### logic/fifo_serial_pkg.sv
/*
 * Shared constants, register layouts and state codes of the FIFO serial port.
 * Assumes one 40 MHz clock and a 32-bit AHB-Lite bus with word transfers only.
 */
package fifo_serial_pkg;

	// ************************************************************
	// register map (byte addresses, low address byte only)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_RXDATA = 8'h0C;
	localparam logic [7:0] OFS_BAUD = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_STANDBY = 8'h1C;

	// ************************************************************
	// field layouts and reset values
	// ************************************************************
	localparam int CTRL_W = 8;
	typedef struct packed {
		logic rx_trigger_sel_hi;
		logic rx_trigger_sel_lo;
		logic tx_trigger_sel_hi;
		logic tx_trigger_sel_lo;
		logic modem_ctrl_en;
		logic tx_fifo_flush;
		logic rx_fifo_flush;
		logic loopback;
	} fifo_control_s;
	localparam fifo_control_s CTRL_RESET = 8'h00;

	typedef struct packed {
		logic [2:0] rsv_hi;
		logic [4:0] tx_count;
		logic [2:0] rsv_lo;
		logic [4:0] rx_count;
	} fill_count_s;

	localparam int BAUD_W = 11;
	typedef struct packed {
		logic ext_clk_sel;
		logic [1:0] prescaler;
		logic [7:0] divisor;
	} baud_cfg_s;
	localparam baud_cfg_s BAUD_RESET = 11'h000;

	localparam int IRQ_W = 4;
	localparam int IRQ_RX_LEVEL = 0;
	localparam int IRQ_TX_SPACE = 1;
	localparam int IRQ_OVERRUN = 2;
	localparam int IRQ_FRAMING = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// ************************************************************
	// fifo geometry and thresholds
	// ************************************************************
	localparam int PTR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam logic [4:0] RTS_STOP_LEVEL = 5'h0F;
	localparam logic [3:0][4:0] RX_TRIG = {5'h0E, 5'h08, 5'h04, 5'h01};
	localparam logic [3:0][4:0] TX_TRIG = {5'h01, 5'h02, 5'h04, 5'h08};

	// ************************************************************
	// timing: prescaler divides by 2*4^n, then divisor by N+1
	// ************************************************************
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int EXT_CLK_MIN_RATIO = 4;
	localparam logic [3:0][6:0] PRESC_LAST = {7'h7F, 7'h1F, 7'h07, 7'h01};
	localparam logic [3:0] HALF_BIT_TICK = 4'h7;
	localparam logic [3:0] LAST_BIT_TICK = 4'hF;
	localparam logic [3:0] TX_LAST_BIT = 4'h9;
	localparam logic [2:0] RX_LAST_BIT = 3'h7;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_FETCH = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;

endpackage : fifo_serial_pkg

// ### logic/fifo_mem.sv
/*
 * Sixteen-entry byte store for one FIFO, one write and one registered read port.
 * Assumes the owner keeps pointers and counts; no reset on the array itself.
 */
module fifo_mem import fifo_serial_pkg::*; (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [PTR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [PTR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem [0:(1<<PTR_W)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : fifo_mem

// ### logic/fifo_serial_port.sv
/*
 * FIFO serial port: control, fill counts, trigger flags, modem handshake,
 * flushes, loopback, baud generator and an 8N1 framer around two FIFOs.
 * Assumes an AHB-Lite master doing single word transfers, synchronous pins.
 */
// Overview of operation
// - receive-level flag when rx count exceeds trigger 1, 4, 8 or 14.
// - transmit-space flag when tx count below trigger 8, 4, 2 or 1.
// - modem enable honours cts and drives rts; else cts low, rts 0.
// - transmit flush bit held one keeps transmit fifo empty.
// - receive flush bit held one keeps receive fifo empty.
// - loopback routes transmit output internally to receive input.
// - reset or standby clears control register and both fifos.
// - control register always readable, writable, returns last written value; in standby writes are ignored and it reads zero.
// - transmit count in bits 12 to 8, zero to sixteen, upper bits zero.
// - receive count in bits 4 to 0, zero to sixteen, bits 7-5 zero.
// - prescaler 0, divisor 0 gives bit rate clock over thirty-two.
// - external clock at most quarter clock; bit rate is its sixteenth.
module fifo_serial_port import fifo_serial_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	output logic txd,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic ext_clk,
	input wire logic standby_mode,
	output logic irq
);
	// ************************************************************
	// bus slave
	// ************************************************************
	fifo_control_s ctrl;
	baud_cfg_s baud;
	logic [IRQ_W-1:0] irq_status, irq_mask;
	logic standby_reg;
	logic [4:0] tx_count, rx_count;
	logic [PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
	logic [DATA_W-1:0] tx_q, rx_q;
	logic dp_write, dp_rx_read;
	logic [7:0] dp_addr;
	logic [31:0] hrdata_q;
	fill_count_s fill;

	wire addr_ok = hsel & hready & htrans[1];
	wire rd_hit = addr_ok & ~hwrite;
	wire [7:0] a = haddr[7:0];
	wire wr_ctrl = dp_write && dp_addr == OFS_CTRL;
	wire wr_txdata = dp_write && dp_addr == OFS_TXDATA;
	wire wr_baud = dp_write && dp_addr == OFS_BAUD;
	wire wr_status = dp_write && dp_addr == OFS_IRQ_STATUS;
	wire wr_mask = dp_write && dp_addr == OFS_IRQ_MASK;
	wire wr_standby = dp_write && dp_addr == OFS_STANDBY;
	wire in_standby = standby_reg | standby_mode;
	wire tx_clear = reset | in_standby | ctrl.tx_fifo_flush;
	wire rx_clear = reset | in_standby | ctrl.rx_fifo_flush;
	wire rx_pop = rd_hit && a == OFS_RXDATA && rx_count != 5'h00 && !rx_clear;

	assign fill.rsv_hi = 3'b000;
	assign fill.tx_count = tx_count;
	assign fill.rsv_lo = 3'b000;
	assign fill.rx_count = rx_count;

	wire [31:0] next_hrdata =
		(a == OFS_CTRL) ? {24'h00_0000, ctrl} :
		(a == OFS_COUNT) ? {16'h0000, fill} :
		(a == OFS_BAUD) ? {21'h00_0000, baud} :
		(a == OFS_IRQ_STATUS) ? {28'h000_0000, irq_status} :
		(a == OFS_IRQ_MASK) ? {28'h000_0000, irq_mask} :
		(a == OFS_STANDBY) ? {31'h0000_0000, standby_reg} : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// rx data comes straight from the fifo store, already a flop
	assign hrdata = dp_rx_read ? {24'h00_0000, rx_q} : hrdata_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			dp_write <= 1'b0;
			dp_rx_read <= 1'b0;
			dp_addr <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			dp_write <= addr_ok & hwrite;
			dp_rx_read <= rd_hit && a == OFS_RXDATA;
			dp_addr <= a;
			hrdata_q <= rd_hit ? next_hrdata : 32'h0000_0000;
		end
	end

	// control cleared by reset and standby
	always_ff @(posedge clk) begin
		if (reset || in_standby) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= hwdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			baud <= BAUD_RESET;
			irq_mask <= IRQ_RESET;
			standby_reg <= 1'b0;
		end else begin
			if (wr_baud) begin
				baud <= hwdata[BAUD_W-1:0];
			end
			if (wr_mask) begin
				irq_mask <= hwdata[IRQ_W-1:0];
			end
			if (wr_standby) begin
				standby_reg <= hwdata[0];
			end
		end
	end

	// ************************************************************
	// baud generator, 16x tick
	// ************************************************************
	logic [6:0] presc_cnt;
	logic [7:0] div_cnt;
	logic ext_q;
	wire presc_done = presc_cnt == PRESC_LAST[baud.prescaler];
	wire int_tick = presc_done && div_cnt == baud.divisor;
	// one tick per external rising edge
	wire ext_tick = ext_clk & ~ext_q;
	wire tick16 = baud.ext_clk_sel ? ext_tick : int_tick;

	always_ff @(posedge clk) begin
		if (reset || baud.ext_clk_sel) begin
			presc_cnt <= 7'h00;
			div_cnt <= 8'h00;
		end else if (presc_done) begin
			presc_cnt <= 7'h00;
			div_cnt <= int_tick ? 8'h00 : div_cnt + 8'h01;
		end else begin
			presc_cnt <= presc_cnt + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= ext_clk;
		end
	end

	// ************************************************************
	// transmit fifo and framer
	// ************************************************************
	tx_state_e tx_state;
	logic [9:0] tx_shift;
	logic [3:0] tx_bit, tx_tick;
	// cts forced active while modem control is off
	wire cts_ok = ~ctrl.modem_ctrl_en | ~cts_n;
	wire tx_push = wr_txdata && tx_count != FIFO_DEPTH && !tx_clear;
	wire tx_pop = tx_state == TX_IDLE && tx_count != 5'h00 && cts_ok && !tx_clear;
	wire tx_line = (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;

	always_ff @(posedge clk) begin
		if (tx_clear) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_count <= 5'h00;
		end else begin
			tx_wp <= tx_wp + PTR_W'(tx_push);
			tx_rp <= tx_rp + PTR_W'(tx_pop);
			tx_count <= tx_count + 5'(tx_push) - 5'(tx_pop);
		end
	end

	fifo_mem tx_mem (
		.clk(clk),
		.wr_en(tx_push),
		.wr_addr(tx_wp),
		.wr_data(hwdata[DATA_W-1:0]),
		.rd_en(tx_pop),
		.rd_addr(tx_rp),
		.rd_data(tx_q)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_state <= TX_IDLE;
			tx_shift <= 10'h3FF;
			tx_bit <= 4'h0;
			tx_tick <= 4'h0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (tx_pop) begin
						tx_state <= TX_FETCH;
					end
				end
				TX_FETCH: begin
					tx_shift <= {1'b1, tx_q, 1'b0};
					tx_bit <= 4'h0;
					tx_tick <= 4'h0;
					tx_state <= TX_SHIFT;
				end
				TX_SHIFT: begin
					if (tick16) begin
						tx_tick <= tx_tick + 4'h1;
						if (tx_tick == LAST_BIT_TICK) begin
							tx_shift <= {1'b1, tx_shift[9:1]};
							tx_bit <= tx_bit + 4'h1;
							if (tx_bit == TX_LAST_BIT) begin
								tx_state <= TX_IDLE;
							end
						end
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	// rts held 0 unless modem control on
	always_ff @(posedge clk) begin
		if (reset) begin
			txd <= 1'b1;
			rts_n <= 1'b0;
		end else begin
			txd <= ctrl.loopback ? 1'b1 : tx_line;
			rts_n <= ctrl.modem_ctrl_en && rx_count >= RTS_STOP_LEVEL;
		end
	end

	// ************************************************************
	// receive framer and fifo
	// ************************************************************
	rx_state_e rx_state;
	logic [3:0] rx_tick;
	logic [2:0] rx_bit;
	logic [DATA_W-1:0] rx_sh;
	wire rx_in = ctrl.loopback ? tx_line : rxd;
	wire rx_done = rx_state == RX_STOP && tick16 && rx_tick == LAST_BIT_TICK;
	wire rx_full = rx_count == FIFO_DEPTH;
	wire rx_push = rx_done && rx_in && !rx_full && !rx_clear;

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_state <= RX_IDLE;
			rx_tick <= 4'h0;
			rx_bit <= 3'h0;
			rx_sh <= 8'h00;
		end else if (tick16) begin
			rx_tick <= rx_tick + 4'h1;
			case (rx_state)
				RX_IDLE: begin
					rx_tick <= 4'h0;
					if (!rx_in) begin
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					// recheck mid start bit, glitches go back to idle
					if (rx_tick == HALF_BIT_TICK) begin
						rx_tick <= 4'h0;
						rx_bit <= 3'h0;
						rx_state <= rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_tick == LAST_BIT_TICK) begin
						rx_sh <= {rx_in, rx_sh[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == RX_LAST_BIT) begin
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_tick == LAST_BIT_TICK) begin
						rx_state <= RX_IDLE;
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rx_clear) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_count <= 5'h00;
		end else begin
			rx_wp <= rx_wp + PTR_W'(rx_push);
			rx_rp <= rx_rp + PTR_W'(rx_pop);
			rx_count <= rx_count + 5'(rx_push) - 5'(rx_pop);
		end
	end

	fifo_mem rx_mem (
		.clk(clk),
		.wr_en(rx_push),
		.wr_addr(rx_wp),
		.wr_data(rx_sh),
		.rd_en(rx_pop),
		.rd_addr(rx_rp),
		.rd_data(rx_q)
	);

	// ************************************************************
	// interrupts: sticky, write one to clear, set wins
	// ************************************************************
	logic [IRQ_W-1:0] events;
	assign events[IRQ_RX_LEVEL] = rx_count > RX_TRIG[{ctrl.rx_trigger_sel_hi, ctrl.rx_trigger_sel_lo}];
	assign events[IRQ_TX_SPACE] = tx_count < TX_TRIG[{ctrl.tx_trigger_sel_hi, ctrl.tx_trigger_sel_lo}];
	assign events[IRQ_OVERRUN] = rx_done && rx_in && rx_full;
	assign events[IRQ_FRAMING] = rx_done && !rx_in;
	wire [IRQ_W-1:0] w1c = wr_status ? hwdata[IRQ_W-1:0] : IRQ_RESET;

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status <= IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~w1c) | events;
		end
	end
	assign irq = |(irq_status & irq_mask);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_rx_level_flag: assert property (events[IRQ_RX_LEVEL] |=> irq_status[IRQ_RX_LEVEL]) else $error("rx flag");
	a_tx_space_flag: assert property (tx_count == 5'h00 |=> irq_status[IRQ_TX_SPACE]) else $error("tx flag");
	a_rts_forced: assert property (!ctrl.modem_ctrl_en |=> !rts_n) else $error("rts not 0");
	a_cts_blocks_tx: assert property (ctrl.modem_ctrl_en && cts_n |-> !tx_pop) else $error("sent on cts");
	a_tx_flush_empty: assert property (ctrl.tx_fifo_flush |=> tx_count == 5'h00) else $error("tx flush");
	a_rx_flush_empty: assert property (ctrl.rx_fifo_flush |=> rx_count == 5'h00) else $error("rx flush");
	a_loop_pin_idle: assert property (ctrl.loopback |=> txd) else $error("txd in loop");
	a_standby_clears: assert property (in_standby |=> ctrl == CTRL_RESET && tx_count == 5'h00) else $error("standby");
	a_ctrl_write_back: assert property (wr_ctrl && !in_standby |=> ctrl == $past(hwdata[CTRL_W-1:0])) else $error("ctrl");
	a_tx_count_step: assert property (tx_push && !tx_pop |=> tx_count == $past(tx_count) + 5'h01) else $error("tx count");
	a_rx_count_bound: assert property (rx_count <= FIFO_DEPTH && tx_count <= FIFO_DEPTH) else $error("count range");
	a_max_int_rate: assert property (int_tick && baud == BAUD_RESET |=> !int_tick ##1 (int_tick || baud != BAUD_RESET)) else $error("rate");
	a_ext_edge_tick: assert property (baud.ext_clk_sel && $rose(ext_clk) |-> tick16) else $error("ext tick");

	c_rx_byte: cover property (rx_push);
	c_tx_frame: cover property (tx_state == TX_SHIFT ##1 tx_state == TX_IDLE);
	c_overrun: cover property (events[IRQ_OVERRUN]);
	c_loop_rx: cover property (ctrl.loopback && rx_push);
endmodule : fifo_serial_port

// ### dv/remote_serial.sv
/*
 * Remote serial device: 8N1 sender on rxd, 8N1 receiver on txd, cts_n driver.
 * Assumes the bench sets the bit time in clocks in bit_cyc and calls its tasks.
 */
module remote_serial #(
	parameter int BIT_CYC = 32
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_rx = 8'h00;
	logic [7:0] shift;
	int frames = 0;
	int bit_cyc = BIT_CYC;
	initial begin
		rxd = 1'h1;
		cts_n = 1'h1;
	end
	task send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bit_cyc) @(posedge clk);
		end
	endtask : send_byte
	task set_cts(input logic v);
		cts_n <= v;
	endtask : set_cts
	always begin
		@(negedge txd);
		repeat (bit_cyc + bit_cyc / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			shift[i] = txd;
			repeat (bit_cyc) @(posedge clk);
		end
		last_rx = shift;
		frames++;
	end
endmodule : remote_serial

// ### dv/fifo_serial_port_tb.sv
/*
 * Self-checking bench of the FIFO serial port: registers over AHB-Lite, serial pins.
 * Assumes the remote_serial model on the pins and zero-wait-state bus answers.
 */
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module fifo_serial_port_tb import fifo_serial_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic standby_mode = 1'h0;
	logic ext_clk = 1'h0;
	logic ext_run = 1'h0;
	logic ext_ph = 1'h0;
	logic hreadyout, hresp, txd, rxd, cts_n, rts_n, irq;
	logic [31:0] hrdata, rd;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	fifo_serial_port u_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
		.ext_clk(ext_clk), .standby_mode(standby_mode), .irq(irq));
	remote_serial u_remote (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// partner clock at a quarter rate
	always @(posedge clk) begin
		ext_ph <= ~ext_ph;
		if (ext_run && ext_ph) begin
			ext_clk <= ~ext_clk;
		end
	end
	// ************************************************************
	// bus access and closing
	// ************************************************************
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : ahb
	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'h1, a, d);
	endtask : wr
	task rdr(input logic [7:0] a);
		ahb(1'h0, a, 32'h0000_0000);
	endtask : rdr
	// bounded: a missing frame leaves last_rx stale and fails the compare
	task wait_frame;
		int f0;
		f0 = u_remote.frames;
		for (int i = 0; i < 1500 && u_remote.frames == f0; i++) @(posedge clk);
	endtask : wait_frame
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset;
		rdr(OFS_CTRL);
		`CHK("ctrl reset", 32'h0000_0000, rd)
		rdr(OFS_COUNT);
		`CHK("count reset", 32'h0000_0000, rd)
		`CHK("rts idle", 1'h0, rts_n)
		`CHK("bus okay", 2'h2, {hreadyout, hresp})
	endtask : t_reset
	task t_ctrl_rw;
		logic [7:0] pat [2] = '{8'hF0, 8'h0F};
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL, {24'h00_0000, pat[i]});
			wr(8'h40, 32'h0000_00FF);
			rdr(OFS_CTRL);
			`CHK("ctrl rw", {24'h00_0000, pat[i]}, rd)
		end
		wr(OFS_CTRL, 32'h0000_0000);
	endtask : t_ctrl_rw
	// mce on and cts_n high keep the transmitter from draining
	task t_tx_levels;
		logic [4:0] thr [4] = '{5'h08, 5'h04, 5'h02, 5'h01};
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, {26'h000_0000, c[1:0], 4'hC});
			wr(OFS_CTRL, {26'h000_0000, c[1:0], 4'h8});
			for (int k = 1; k < thr[c]; k++) wr(OFS_TXDATA, 32'h0000_0011);
			wr(OFS_IRQ_STATUS, 32'h0000_0002);
			rdr(OFS_IRQ_STATUS);
			`CHK("tx space below", 1'h1, rd[IRQ_TX_SPACE])
			wr(OFS_TXDATA, 32'h0000_0011);
			wr(OFS_IRQ_STATUS, 32'h0000_0002);
			rdr(OFS_IRQ_STATUS);
			`CHK("tx space at", 1'h0, rd[IRQ_TX_SPACE])
		end
		wr(OFS_CTRL, 32'h0000_000C);
		wr(OFS_CTRL, 32'h0000_0008);
		for (int k = 0; k < 17; k++) wr(OFS_TXDATA, 32'h0000_0011);
		rdr(OFS_COUNT);
		`CHK("tx full count", 32'h0000_1000, rd)
		wr(OFS_CTRL, 32'h0000_000C);
		wr(OFS_TXDATA, 32'h0000_0011);
		rdr(OFS_COUNT);
		`CHK("tx flushed", 32'h0000_0000, rd)
		wr(OFS_CTRL, 32'h0000_0008);
	endtask : t_tx_levels
	task t_tx_cts;
		wr(OFS_TXDATA, 32'h0000_003C);
		repeat (100) @(posedge clk);
		rdr(OFS_COUNT);
		`CHK("held by cts", 32'h0000_0100, rd)
		u_remote.set_cts(1'h0);
		wait_frame();
		`CHK("tx byte", 8'h3C, u_remote.last_rx)
		u_remote.set_cts(1'h1);
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_TXDATA, 32'h0000_00A5);
		wait_frame();
		`CHK("cts ignored", 8'hA5, u_remote.last_rx)
	endtask : t_tx_cts
	task t_rx_levels;
		logic [4:0] thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, {24'h00_0000, c[1:0], 6'h02});
			wr(OFS_CTRL, {24'h00_0000, c[1:0], 6'h00});
			for (int k = 0; k < thr[c]; k++) u_remote.send_byte(8'h40 + 8'(k));
			wr(OFS_IRQ_STATUS, 32'h0000_0001);
			rdr(OFS_IRQ_STATUS);
			`CHK("rx level at", 1'h0, rd[IRQ_RX_LEVEL])
			u_remote.send_byte(8'h7E);
			wr(OFS_IRQ_STATUS, 32'h0000_0001);
			rdr(OFS_IRQ_STATUS);
			`CHK("rx level above", 1'h1, rd[IRQ_RX_LEVEL])
		end
		// irq looked at once the write's edge has settled
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		@(negedge clk);
		`CHK("irq raised", 1'h1, irq)
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		@(negedge clk);
		`CHK("irq masked", 1'h0, irq)
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_00C8);
		rdr(OFS_COUNT);
		`CHK("rx count", 32'h0000_000F, rd)
		`CHK("rts stop", 1'h1, rts_n)
		rdr(OFS_RXDATA);
		`CHK("rx first", 8'h40, rd[7:0])
		wr(OFS_IRQ_STATUS, 32'h0000_0001);
		@(negedge clk);
		`CHK("irq cleared", 1'h0, irq)
		`CHK("rts go", 1'h0, rts_n)
		wr(OFS_CTRL, 32'h0000_0002);
		rdr(OFS_COUNT);
		`CHK("rx flushed", 32'h0000_0000, rd)
		wr(OFS_CTRL, 32'h0000_0000);
	endtask : t_rx_levels
	task t_loopback;
		int f0;
		f0 = u_remote.frames;
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_TXDATA, 32'h0000_0096);
		repeat (400) @(posedge clk);
		rdr(OFS_COUNT);
		`CHK("loop count", 32'h0000_0001, rd)
		rdr(OFS_RXDATA);
		`CHK("loop byte", 8'h96, rd[7:0])
		`CHK("pin quiet", f0, u_remote.frames)
		wr(OFS_CTRL, 32'h0000_0000);
	endtask : t_loopback
	// divisor 1 and the external clock both give 64 clocks per bit
	task t_baud;
		u_remote.bit_cyc = 64;
		wr(OFS_BAUD, 32'h0000_0001);
		wr(OFS_TXDATA, 32'h0000_005A);
		wait_frame();
		`CHK("tx divisor 1", 8'h5A, u_remote.last_rx)
		ext_run <= 1'h1;
		wr(OFS_BAUD, 32'h0000_0400);
		wr(OFS_TXDATA, 32'h0000_00C3);
		wait_frame();
		`CHK("tx ext clock", 8'hC3, u_remote.last_rx)
		u_remote.send_byte(8'h3A);
		rdr(OFS_RXDATA);
		`CHK("rx ext clock", 8'h3A, rd[7:0])
		wr(OFS_BAUD, 32'h0000_0000);
		ext_run <= 1'h0;
		u_remote.bit_cyc = 32;
	endtask : t_baud
	// cts_n still high here, so the pushed byte waits in the fifo
	task t_mid_reset;
		wr(OFS_CTRL, 32'h0000_00F8);
		wr(OFS_TXDATA, 32'h0000_0011);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		rdr(OFS_CTRL);
		`CHK("ctrl mid reset", 32'h0000_0000, rd)
		rdr(OFS_COUNT);
		`CHK("count mid reset", 32'h0000_0000, rd)
	endtask : t_mid_reset
	task t_standby;
		wr(OFS_CTRL, 32'h0000_00F8);
		u_remote.send_byte(8'h22);
		standby_mode <= 1'h1;
		repeat (2) @(posedge clk);
		standby_mode <= 1'h0;
		rdr(OFS_CTRL);
		`CHK("ctrl standby", 32'h0000_0000, rd)
		rdr(OFS_COUNT);
		`CHK("fifos standby", 32'h0000_0000, rd)
	endtask : t_standby
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		t_reset();
		t_ctrl_rw();
		t_tx_levels();
		t_tx_cts();
		t_rx_levels();
		t_loopback();
		t_baud();
		t_mid_reset();
		t_standby();
		give_verdict();
	end
endmodule : fifo_serial_port_tb
